// [rtl/timer_pkg.sv]
package timer_pkg;

    // bus geometry: byte address is four times the register index
    localparam int unsigned ADR_W = 10;
    localparam int unsigned DAT_W = 32;
    localparam int unsigned SEL_W = 4;

    // register indices
    localparam logic [7:0] IDX_FLAGS  = 8'h36;
    localparam logic [7:0] IDX_MASK   = 8'h6F;
    localparam logic [7:0] IDX_CLKSEL = 8'h70;
    localparam logic [7:0] IDX_SYNC   = 8'h71;

    // flag and mask bit positions
    localparam int unsigned BIT_OVF     = 0;
    localparam int unsigned BIT_CMP_A   = 1;
    localparam int unsigned BIT_CMP_B   = 2;
    localparam int unsigned BIT_CAPTURE = 5;
    localparam logic [7:0]  USED_BITS   = 8'h27;
    localparam logic [7:0]  FLAGS_RST   = 8'h00;
    localparam logic [7:0]  MASK_RST    = 8'h00;

    // clock select register fields
    localparam int unsigned CS16_LSB = 0;
    localparam int unsigned CS8_LSB  = 3;

    // prescaler sync register fields
    localparam int unsigned SYNC_TSM_BIT = 7;
    localparam int unsigned SYNC_PSR_BIT = 0;

    // clock select codes, in documented order 0..7
    typedef enum logic [2:0] {
        CS_STOP, CS_DIRECT, CS_DIV8, CS_DIV64,
        CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
    } clk_sel_e;
    localparam clk_sel_e CS_RST = CS_STOP;

    // prescaler: one tap fires when the low bits of the count are all ones
    localparam int unsigned PRESC_W = 10;
    localparam int unsigned TAP_N   = 4;
    typedef logic [PRESC_W-1:0] presc_t;
    localparam presc_t TAP_MASK [TAP_N] = '{
        10'h007, 10'h03F, 10'h0FF, 10'h3FF
    };

    // byte address of a register index
    function automatic logic [ADR_W-1:0] regAddr(input logic [7:0] idx);
        return {idx, 2'b00};
    endfunction : regAddr

    // waveform modes 8, 10, 12, 14 use the capture register as top
    function automatic logic capTopMode(input logic [3:0] wgm);
        return wgm[3] & ~wgm[0];
    endfunction : capTopMode

endpackage : timer_pkg

// [rtl/presc_if.sv]
`timescale 1ns/1ns
`default_nettype none

// prescaler taps and synchronised pin edges, one-cycle pulses
interface presc_if;
    logic [3:0] tapPulse;   // div 8, 64, 256, 1024
    logic       extRise;    // rising edge of the count pin
    logic       extFall;    // falling edge of the count pin
    modport source (output tapPulse, output extRise, output extFall);
    modport sink   (input  tapPulse, input  extRise, input  extFall);
endinterface : presc_if

`default_nettype wire

// [rtl/presc_edge.sv]
`timescale 1ns/1ns
`default_nettype none

module presc_edge (
    input  wire logic    clk,
    input  wire logic    rst_n,
    input  wire logic    prescReset,
    input  wire logic    extClkPin,
    presc_if.source      taps
);
    import timer_pkg::*;

    // all state of the prescaler and pin edge detector
    typedef struct packed {
        presc_t     cnt;       // free running divider
        logic       pinMeta;   // first synchroniser stage
        logic       pinSync;   // second synchroniser stage
        logic       pinPrev;   // previous synchronised level
        logic [3:0] tap;       // tap pulses
        logic       rise;      // rising edge pulse
        logic       fall;      // falling edge pulse
    } presc_s;

    presc_s s_r;
    presc_s s_nxt;

    // next state: divider, synchroniser, edge detector
    always_comb begin
        s_nxt = s_r;
        // sampled every cycle, two flops before the detector [R18] [R19]
        s_nxt.pinMeta = extClkPin;
        s_nxt.pinSync = s_r.pinMeta;
        s_nxt.pinPrev = s_r.pinSync;
        // one pulse per edge in either direction [R20]
        s_nxt.rise = s_r.pinSync & ~s_r.pinPrev;
        s_nxt.fall = ~s_r.pinSync & s_r.pinPrev;
        // divider runs regardless of any clock select [R14] [R15]
        if (prescReset) begin
            s_nxt.cnt = '0;
        end else begin
            s_nxt.cnt = s_r.cnt + presc_t'(1);
        end
        // four divided taps [R13]
        for (int i = 0; i < TAP_N; i++) begin
            s_nxt.tap[i] = ~prescReset &
                           ((s_r.cnt & TAP_MASK[i]) == TAP_MASK[i]);
        end
    end

    // state register, synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign taps.tapPulse = s_r.tap;
    assign taps.extRise  = s_r.rise;
    assign taps.extFall  = s_r.fall;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_presc_restart: assert property (prescReset |=> s_r.cnt == '0 // [R15]
        && s_r.tap == 4'h0) else $error("prescaler not restarted");
    a_div8_spacing: assert property (s_r.tap[0] |=> !s_r.tap[0] [*7]) // [R13]
        else $error("div 8 tap too frequent");
    a_edge_single: assert property (s_r.rise |=> !s_r.rise // [R20]
        && !s_r.fall) else $error("edge pulse longer than one cycle");
    c_tap1024: cover property (s_r.tap[3]);

endmodule : presc_edge

`default_nettype wire

// [rtl/timer_irq_top.sv]
// Behaviour
// R1 - irq needs mask, global enable and flag
// R2 - unused bits 7,6,4,3 read zero
// R3 - capture event sets capture flag
// R4 - capture-top mode: top reached sets capture flag
// R5 - vector execution clears its own flag
// R6 - writing one clears a flag
// R7 - writing zero leaves a flag alone
// R8 - compare flag set one tick after match
// R9 - forced compare never sets compare flag
// R10 - overflow event sets overflow flag
// R11 - shared prescaler, separate clock selects
// R12 - select 1 ticks every system cycle
// R13 - taps divide by 8, 64, 256, 1024
// R14 - prescaler free running, first tick 1..N+1
// R15 - prescaler reset restarts both timers' taps
// R16 - reset bit self clears unless sync mode
// R17 - select 0 stops, 2..5 pick taps
// R18 - pin sampled each cycle then edge detected
// R19 - sampling on rising system clock edge
// R20 - select 7 rising, 6 falling pin edges
// R21 - pin edge to tick about three cycles; this design takes four cycles
// R22 - software changes select with pin stable
// R23 - pin half period above one cycle
// R24 - pin edges bypass the prescaler
`timescale 1ns/1ns
`default_nettype none

module timer_irq_top (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // wishbone classic slave
    input  wire logic [timer_pkg::ADR_W-1:0] adr_i,
    input  wire logic [timer_pkg::DAT_W-1:0] dat_i,
    output logic      [timer_pkg::DAT_W-1:0] dat_o,
    input  wire logic                      we_i,
    input  wire logic [timer_pkg::SEL_W-1:0] sel_i,
    input  wire logic                      cyc_i,
    input  wire logic                      stb_i,
    output logic                           ack_o,
    // core side
    input  wire logic                      globalIrqEn,
    input  wire logic [3:0]                vecAck,
    output logic      [3:0]                irqReq,
    // counter datapath side
    input  wire logic [3:0]                waveformModeBits,
    input  wire logic                      captureEvent,
    input  wire logic                      counterAtTop,
    input  wire logic                      cmpAMatch,
    input  wire logic                      cmpBMatch,
    input  wire logic                      forceCmpAStrobe,
    input  wire logic                      forceCmpBStrobe,
    input  wire logic                      overflowEvent,
    input  wire logic                      extClkPin,
    output logic                           timer16Tick,
    output logic                           timer8Tick
);
    import timer_pkg::*;

    // all state of the block
    typedef struct packed {
        logic [7:0] flags;    // interrupt flags
        logic [7:0] mask;     // interrupt mask
        clk_sel_e   cs16;     // 16-bit timer clock select
        clk_sel_e   cs8;      // 8-bit timer clock select
        logic       timer_sync_mode;      // sync mode
        logic       psr;      // shared prescaler reset
        logic       ack;      // bus acknowledge
        logic [7:0] rdat;     // read data
        logic [3:0] irq;      // interrupt requests
        logic       tick16;   // 16-bit timer clock enable
        logic       tick8;    // 8-bit timer clock enable
    } state_s;

    state_s s_r;
    state_s s_nxt;

    presc_if pif ();          // taps and pin edges

    // shared prescaler and pin edge detector
    presc_edge presc_edge_inst (
        .clk        (clk),
        .rst_n      (rst_n),
        .prescReset (s_r.psr),
        .extClkPin  (extClkPin),
        .taps       (pif.source)
    );

    // combinational helpers, given values at the top of the process
    logic       busReq;       // new request not yet answered
    logic       wrEn;         // write to byte lane 0
    logic       wrFlags;      // write hits the flag register
    logic [7:0] setFlags;     // hardware events
    logic [7:0] clrFlags;     // vector and software clears
    logic [7:0] wByte;        // written byte

    // clock enable from a clock select code
    function automatic logic pickTick(input clk_sel_e cs,
                                      input logic [3:0] tap,
                                      input logic rise,
                                      input logic fall);
        logic t;
        t = 1'b0;
        unique case (cs)
            CS_STOP:     t = 1'b0;        // no clock [R17]
            CS_DIRECT:   t = 1'b1;        // undivided [R12]
            CS_DIV8:     t = tap[0];      // divided taps [R13] [R17]
            CS_DIV64:    t = tap[1];
            CS_DIV256:   t = tap[2];
            CS_DIV1024:  t = tap[3];
            CS_EXT_FALL: t = fall;        // pin, no prescale [R20] [R24]
            CS_EXT_RISE: t = rise;        // [R20] [R24]
        endcase
        return t;
    endfunction : pickTick

    // next state: bus, flags, mask, clock selects, requests
    always_comb begin
        s_nxt    = s_r;
        busReq   = cyc_i & stb_i & ~s_r.ack;
        wrEn     = busReq & we_i & sel_i[0];
        wByte    = dat_i[7:0];
        wrFlags  = wrEn & (adr_i == regAddr(IDX_FLAGS));
        setFlags = 8'h00;
        clrFlags = 8'h00;

        // answer every request one cycle later, drop after one cycle
        s_nxt.ack  = busReq;
        s_nxt.rdat = s_r.rdat;
        if (busReq) begin
            unique case (adr_i)
                // unused bits of flags and mask read as zero [R2]
                regAddr(IDX_FLAGS):  s_nxt.rdat = s_r.flags & USED_BITS;
                regAddr(IDX_MASK):   s_nxt.rdat = s_r.mask & USED_BITS;
                regAddr(IDX_CLKSEL): s_nxt.rdat = {2'b00, s_r.cs8, s_r.cs16};
                regAddr(IDX_SYNC):   s_nxt.rdat = {s_r.timer_sync_mode, 6'h00, s_r.psr};
                default:             s_nxt.rdat = 8'h00;   // unmapped
            endcase
        end

        // flag events; datapath events other than captureEvent count only on a 16-bit tick
        setFlags[BIT_CAPTURE] = captureEvent                        // [R3]
            | (s_r.tick16 & counterAtTop
               & capTopMode(waveformModeBits));                     // [R4]
        // the match seen at this tick ends the matching timer cycle
        setFlags[BIT_CMP_A] = s_r.tick16 & cmpAMatch
                              & ~forceCmpAStrobe;               // [R8] [R9]
        setFlags[BIT_CMP_B] = s_r.tick16 & cmpBMatch
                              & ~forceCmpBStrobe;               // [R8] [R9]
        setFlags[BIT_OVF]   = s_r.tick16 & overflowEvent;          // [R10]

        // vector execution clears [R5]
        clrFlags[BIT_OVF]     = vecAck[0];
        clrFlags[BIT_CMP_A]   = vecAck[1];
        clrFlags[BIT_CMP_B]   = vecAck[2];
        clrFlags[BIT_CAPTURE] = vecAck[3];
        // write one clears, write zero keeps [R6] [R7]
        if (wrFlags) begin
            clrFlags = clrFlags | wByte;
        end
        // a set in the clearing cycle wins
        s_nxt.flags = ((s_r.flags & ~clrFlags) | setFlags) & USED_BITS;

        // mask and clock select writes
        if (wrEn && adr_i == regAddr(IDX_MASK)) begin
            s_nxt.mask = wByte & USED_BITS;
        end
        if (wrEn && adr_i == regAddr(IDX_CLKSEL)) begin
            // independent selects on one prescaler [R11]
            s_nxt.cs16 = clk_sel_e'(wByte[CS16_LSB +: 3]);
            s_nxt.cs8  = clk_sel_e'(wByte[CS8_LSB +: 3]);
        end

        // prescaler reset: held only while sync mode is on [R16]
        if (wrEn && adr_i == regAddr(IDX_SYNC)) begin
            s_nxt.timer_sync_mode = wByte[SYNC_TSM_BIT];
            s_nxt.psr = wByte[SYNC_PSR_BIT];
        end else if (!s_r.timer_sync_mode) begin
            s_nxt.psr = 1'b0;
        end

        // requests need mask, global enable and flag [R1]
        s_nxt.irq[0] = globalIrqEn & s_r.mask[BIT_OVF]
                       & s_r.flags[BIT_OVF];
        s_nxt.irq[1] = globalIrqEn & s_r.mask[BIT_CMP_A]
                       & s_r.flags[BIT_CMP_A];
        s_nxt.irq[2] = globalIrqEn & s_r.mask[BIT_CMP_B]
                       & s_r.flags[BIT_CMP_B];
        s_nxt.irq[3] = globalIrqEn & s_r.mask[BIT_CAPTURE]
                       & s_r.flags[BIT_CAPTURE];

        // timer clock enables, pin edge to tick in four cycles [R21]
        s_nxt.tick16 = pickTick(s_r.cs16, pif.tapPulse,
                                pif.extRise, pif.extFall);  // [R11]
        s_nxt.tick8  = pickTick(s_r.cs8, pif.tapPulse,
                                pif.extRise, pif.extFall);  // [R11]
    end

    // state register, synchronous reset to documented values
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r        <= '0;
            s_r.flags  <= FLAGS_RST;
            s_r.mask   <= MASK_RST;
            s_r.cs16   <= CS_RST;
            s_r.cs8    <= CS_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign ack_o       = s_r.ack;
    assign dat_o       = {{(DAT_W-8){1'b0}}, s_r.rdat};
    assign irqReq      = s_r.irq;
    assign timer16Tick = s_r.tick16;
    assign timer8Tick  = s_r.tick8;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // helper: flag register read answered on the bus
    logic rdFlagsQ;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdFlagsQ <= 1'b0;
        end else begin
            rdFlagsQ <= busReq & ~we_i & (adr_i == regAddr(IDX_FLAGS));
        end
    end

    a_irq_needs_gie: assert property (irqReq != 4'h0 |-> // [R1]
        $past(globalIrqEn)) else $error("irq without global enable");
    a_irq_follows: assert property (globalIrqEn // [R1]
        && s_r.mask[BIT_CMP_A] && s_r.flags[BIT_CMP_A] |=> irqReq[1])
        else $error("compare A irq missing");
    a_flags_unused: assert property (rdFlagsQ |-> ack_o // [R2]
        && dat_o[7:6] == 2'b00 && dat_o[4:3] == 2'b00)
        else $error("unused flag bits not zero");
    a_capture_sets: assert property (captureEvent // [R3]
        |=> s_r.flags[BIT_CAPTURE]) else $error("capture flag not set");
    a_top_capture: assert property (timer16Tick && counterAtTop // [R4]
        && capTopMode(waveformModeBits) |=> s_r.flags[BIT_CAPTURE])
        else $error("top did not set capture flag");
    a_vector_clear: assert property (vecAck[0] && !overflowEvent // [R5]
        |=> !s_r.flags[BIT_OVF]) else $error("vector did not clear");
    a_w1c_clears: assert property (wrFlags && wByte[BIT_CMP_B] // [R6]
        && !setFlags[BIT_CMP_B] |=> !s_r.flags[BIT_CMP_B])
        else $error("write one did not clear");
    a_w0_keeps: assert property (wrFlags && !wByte[BIT_OVF] // [R7]
        && !vecAck[0] && s_r.flags[BIT_OVF] |=> s_r.flags[BIT_OVF])
        else $error("write zero cleared a flag");
    a_cmp_a_sets: assert property (timer16Tick && cmpAMatch // [R8]
        && !forceCmpAStrobe |=> s_r.flags[BIT_CMP_A])
        else $error("compare A flag not set");
    a_force_quiet: assert property (!s_r.flags[BIT_CMP_A] // [R9]
        && forceCmpAStrobe && !captureEvent |=> !s_r.flags[BIT_CMP_A])
        else $error("forced compare set a flag");
    a_ovf_sets: assert property (timer16Tick && overflowEvent // [R10]
        |=> s_r.flags[BIT_OVF]) else $error("overflow flag not set");
    a_direct_tick: assert property (s_r.cs16 == CS_DIRECT [*2] // [R12]
        |-> timer16Tick) else $error("direct select did not tick");
    a_stop_quiet: assert property (s_r.cs8 == CS_STOP [*2] // [R17]
        |-> !timer8Tick) else $error("stopped timer ticked");
    a_psr_selfclr: assert property (s_r.psr && !s_r.timer_sync_mode && !wrEn // [R16]
        |=> !s_r.psr) else $error("prescaler reset stuck");
    a_ext_bypass: assert property (s_r.cs16 == CS_EXT_RISE // [R24]
        && pif.extRise |=> timer16Tick) else $error("pin edge lost");

    c_irq_capture: cover property (irqReq[3]);
    c_set_and_clear: cover property (wrFlags && setFlags != 8'h00);
    c_sync_hold: cover property (s_r.timer_sync_mode && s_r.psr [*3]);
    c_ext_fall: cover property (s_r.cs8 == CS_EXT_FALL && timer8Tick);

endmodule : timer_irq_top

`default_nettype wire

// [dv/core_model.sv]
`timescale 1ns/1ns
`default_nettype none

// core side: wishbone classic master and vector execution
module core_model (
    input  wire logic                        clk,
    input  wire logic                        ackEn,  // vectors taken
    input  wire logic [2:0]                  lat,    // wait, 1 or more
    input  wire logic [3:0]                  irqReq,
    input  wire logic                        ack,
    input  wire logic [timer_pkg::DAT_W-1:0] datIn,
    output var  logic [timer_pkg::ADR_W-1:0] adr,
    output var  logic [timer_pkg::DAT_W-1:0] datOut,
    output var  logic [timer_pkg::SEL_W-1:0] sel,
    output var  logic                        we,
    output var  logic                        cyc,
    output var  logic                        stb,
    output var  logic [3:0]                  vecAck
);
    import timer_pkg::*;
    logic [2:0] wait_r;  // cycles spent before the next vector

    // idle bus, no vector
    initial begin
        {adr, datOut, sel, we, cyc, stb} = '0;
        vecAck = 4'h0;
        wait_r = 3'h0;
    end

    // one classic cycle: hold the request until ack is sampled high
    // no local limit: only the bench's cycle ceiling ends a hang
    task automatic wbXfer(input logic wr, input logic [ADR_W-1:0] a,
                          input logic [SEL_W-1:0] s,
                          input logic [DAT_W-1:0] d,
                          output logic [DAT_W-1:0] q, output logic ok);
        @(posedge clk);
        {cyc, stb, we, adr, sel, datOut} <= {2'b11, wr, a, s, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = datIn;
        ok = (ack === 1'b1);
        {cyc, stb, we} <= 3'b000;
    endtask : wbXfer

    // run the lowest pending vector after lat cycles, one-cycle pulse
    always @(posedge clk) begin
        if (vecAck != 4'h0) begin
            vecAck <= 4'h0;
        end else if (!ackEn || irqReq == 4'h0) begin
            wait_r <= 3'h0;
        end else if (wait_r == lat) begin
            vecAck <= irqReq & (~irqReq + 4'h1);
            wait_r <= 3'h0;
        end else begin
            wait_r <= wait_r + 3'h1;
        end
    end
endmodule : core_model

`default_nettype wire

// [dv/timer_prescaler_and_irq_flags_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    mismatches++; $display("MISMATCH %s exp %h got %h", nm, (e), (g)); end end

module timer_prescaler_and_irq_flags_tb;
    import timer_pkg::*;
    localparam int LIMIT = 40000;  // cycle ceiling of the run
    localparam logic [6:0] EV_VEC [8] = '{7'h10, 7'h08, 7'h01, 7'h40,
                                         7'h20, 7'h20, 7'h14, 7'h0A};
    localparam logic [3:0] EV_MODE [8] = '{4'h0, 4'h0, 4'h0, 4'h0,
                                          4'hC, 4'h0, 4'h0, 4'h0};
    localparam logic [7:0] EV_EXP [8] = '{8'h02, 8'h04, 8'h01, 8'h20,
                                         8'h20, 8'h00, 8'h00, 8'h00};
    logic             clk, rst_n, we, cyc, stb, ack, gie, ackEn, pin, ok;
    logic             capEv, atTop, mA, mB, fA, fB, ovf, t16, t8;
    logic [ADR_W-1:0] adr;
    logic [DAT_W-1:0] datW, datR, q;
    logic [SEL_W-1:0] sel;
    logic [3:0]       vecAck, irqReq, wgm;
    logic [2:0]       lat;
    logic [7:0]       w, m;
    logic [15:0]      c16, c8;  // ticks seen in a window
    int               mismatches, n_compared, cycles, k;

    timer_irq_top timer_irq_top_inst (.clk(clk), .rst_n(rst_n), .adr_i(adr),
        .dat_i(datW), .dat_o(datR), .we_i(we), .sel_i(sel), .cyc_i(cyc),
        .stb_i(stb), .ack_o(ack), .globalIrqEn(gie), .vecAck(vecAck),
        .irqReq(irqReq), .waveformModeBits(wgm), .captureEvent(capEv),
        .counterAtTop(atTop), .cmpAMatch(mA), .cmpBMatch(mB),
        .forceCmpAStrobe(fA), .forceCmpBStrobe(fB), .overflowEvent(ovf),
        .extClkPin(pin), .timer16Tick(t16), .timer8Tick(t8));
    core_model core_model_inst (.clk(clk), .ackEn(ackEn), .lat(lat),
        .irqReq(irqReq), .ack(ack), .datIn(datR), .adr(adr), .datOut(datW),
        .sel(sel), .we(we), .cyc(cyc), .stb(stb), .vecAck(vecAck));

    // 25 MHz system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // verdict and end of run
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            give_verdict();
        end
    end

    // register access; a missing ack counts as a mismatch
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [3:0] s, input logic [7:0] v);
        core_model_inst.wbXfer(wr, {idx, 2'b00}, s, {24'h0, v}, q, ok);
        `CHK("ack", 1'b1, ok)
    endtask : xfer
    task automatic rdChk(input string nm, input logic [7:0] idx,
                         input logic [7:0] e);
        xfer(1'b0, idx, 4'hF, 8'h00);
        `CHK(nm, {24'h0, e}, q)
    endtask : rdChk

    // datapath events held over two direct ticks
    task automatic ev(input logic [6:0] v);
        {capEv, atTop, mA, mB, fA, fB, ovf} <= v;
        repeat (2) @(posedge clk);
        {capEv, atTop, mA, mB, fA, fB, ovf} <= 7'h00;
        @(posedge clk);
    endtask : ev

    // tick counts over n cycles
    task automatic count(input int n);
        c16 = '0;
        c8 = '0;
        repeat (n) begin
            @(posedge clk);
            c16 = c16 + 16'(t16);
            c8 = c8 + 16'(t8);
        end
    endtask : count

    // pin toggles every third cycle, changed only while select is steady
    task automatic pinBurst(input int n);
        repeat (n) begin
            repeat (3) @(posedge clk);
            pin <= ~pin;
        end
    endtask : pinBurst

    function automatic logic [15:0] tickExp(input int c, input int n);
        case (c)
            1: return 16'(n);
            2: return 16'(n / 8);
            3: return 16'(n / 64);
            4: return 16'(n / 256);
            5: return 16'(n / 1024);
            default: return 16'h0000;
        endcase
    endfunction : tickExp

    function automatic logic [3:0] irqExp(input logic [7:0] f, mk,
                                          input logic g);
        return g ? {f[5] & mk[5], f[2] & mk[2], f[1] & mk[1], f[0] & mk[0]}
                 : 4'h0;
    endfunction : irqExp

    // main sequence
    initial begin
        void'($urandom(45));
        {rst_n, gie, ackEn, pin, capEv, atTop, mA, mB, fA, fB, ovf} = '0;
        wgm = 4'h0;
        lat = 3'h1;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rdChk("flagsRst", IDX_FLAGS, 8'h00);
        rdChk("maskRst", IDX_MASK, 8'h00);
        rdChk("unmapped", 8'h00, 8'h00);
        xfer(1'b1, IDX_CLKSEL, 4'hF, 8'h01);
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, IDX_FLAGS, 4'hF, 8'hFF);
            wgm <= EV_MODE[i];
            ev(EV_VEC[i]);
            rdChk("flagSet", IDX_FLAGS, EV_EXP[i]);
        end
        for (int i = 0; i < 5; i++) begin
            w = (i == 0) ? 8'h00 : 8'($urandom);
            ev(7'h59);
            xfer(1'b1, IDX_FLAGS, 4'hF, w);
            rdChk("flagClr", IDX_FLAGS, 8'h27 & ~w);
        end
        ev(7'h59);
        for (int i = 0; i < 6; i++) begin
            m = (i == 0) ? 8'hFF : 8'($urandom);
            gie <= (i % 2 == 0);
            xfer(1'b1, IDX_MASK, 4'hF, m);
            rdChk("maskRd", IDX_MASK, m & USED_BITS);
            `CHK("irqReq", irqExp(8'h27, m, (i % 2 == 0)), irqReq)
        end
        xfer(1'b1, IDX_MASK, 4'h0, 8'h00);
        rdChk("maskSel", IDX_MASK, m & USED_BITS);
        for (int i = 0; i < 2; i++) begin
            ev(7'h59);
            gie <= 1'b1;
            lat <= (i == 0) ? 3'h1 : 3'h6;
            xfer(1'b1, IDX_MASK, 4'hF, 8'h25);
            ackEn <= 1'b1;
            repeat (40) @(posedge clk);
            ackEn <= 1'b0;
            rdChk("vecClr", IDX_FLAGS, 8'h02);
        end
        for (int s = 0; s < 6; s++) begin
            xfer(1'b1, IDX_CLKSEL, 4'hF, 8'((5 - s) * 8 + s));
            repeat (4) @(posedge clk);
            count(2048);
            `CHK("tick16", tickExp(s, 2048), c16)
            `CHK("tick8", tickExp(5 - s, 2048), c8)
        end
        xfer(1'b1, IDX_SYNC, 4'hF, 8'h01);
        rdChk("psrSelf", IDX_SYNC, 8'h00);
        xfer(1'b1, IDX_SYNC, 4'hF, 8'h81);
        rdChk("psrHeld", IDX_SYNC, 8'h81);
        xfer(1'b1, IDX_CLKSEL, 4'hF, 8'h12);
        count(64);
        `CHK("held16", 16'h0000, c16)
        `CHK("held8", 16'h0000, c8)
        xfer(1'b1, IDX_SYNC, 4'hF, 8'h00);
        count(64);
        // restart at the write edge: first tick seen 10 edges on, then
        // every 8, so a 64-cycle window from the return holds 7 ticks
        `CHK("run16", 16'h0007, c16)
        `CHK("run8", 16'h0007, c8)
        for (int c = 6; c < 8; c++) begin
            xfer(1'b1, IDX_CLKSEL, 4'hF, 8'(c * 9));
            repeat (3) @(posedge clk);
            fork
                pinBurst(20);
                count(68);
            join
            `CHK("pin16", 16'h000A, c16)
            `CHK("pin8", 16'h000A, c8)
        end
        repeat (3) @(posedge clk);
        pin <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (t16 !== 1'b1 && k < 10);
        `CHK("pinLat", 1'b1, (k >= 3 && k <= 5))
        give_verdict();
    end
endmodule : timer_prescaler_and_irq_flags_tb

`default_nettype wire
